// ### hdl/amcs_consts.vh
`ifndef AMCS_CONSTS_VH
`define AMCS_CONSTS_VH
// Register byte offsets
`define AMCS_OFS_MODE 5'h00
`define AMCS_OFS_CONFIG 5'h04
`define AMCS_OFS_STATUS 5'h08
`define AMCS_OFS_IRQ_STAT 5'h0C
`define AMCS_OFS_IRQ_MASK 5'h10
`define AMCS_OFS_OFF_COEF 5'h14
`define AMCS_OFS_FS_COEF 5'h18
// Operating-mode codes
`define AMCS_MD_CONT 3'h0
`define AMCS_MD_SINGLE 3'h1
`define AMCS_MD_IDLE 3'h2
`define AMCS_MD_PDOWN 3'h3
`define AMCS_MD_ZS_CAL 3'h4
`define AMCS_MD_FS_CAL 3'h5
`define AMCS_MD_SYS_OFF 3'h6
`define AMCS_MD_SYS_FS 3'h7
// Config fields
`define AMCS_CFG_CH_LSB 0
`define AMCS_CFG_GAIN_LSB 4
`define AMCS_CFG_BO_BIT 8
`define AMCS_GAIN_1 3'h0
`define AMCS_GAIN_128 3'h7
// Interrupt status bits
`define AMCS_IRQ_CONV 0
`define AMCS_IRQ_CAL 1
`define AMCS_IRQ_REFUSE 2
// Reset values
`define AMCS_RST_GAIN 3'h7
`define AMCS_RST_OFF_COEF 24'h800000
`define AMCS_RST_FS_COEF 24'h500000
// Calibration lengths in conversion cycles
`define AMCS_CAL_CYC_SHORT 3'h2
`define AMCS_CAL_CYC_LONG 3'h4
// Bus responses
`define AMCS_RESP_OKAY 2'h0
`define AMCS_RESP_SLVERR 2'h2
`endif

// ### hdl/amcs_sequencer.v
// How it works
// - Mode field 000 continuous (reset default), 001 single, 010 idle, 011 power-down.
// - Idle holds filter and modulator in reset while modulator clocks keep running.
// - Power-down turns off everything, including low-side switch and burnout currents.
// - Internal zero-scale shorts the channel inputs and lasts two conversion cycles.
// - Ready flag goes high at calibration start and low when it completes.
// - After any calibration the device goes idle until a new mode is written.
// - Zero-scale and system offset results land in the selected channel's offset register.
// - Internal full-scale connects full-scale input; two cycles at gain 1, four at the gains between, refused at gain 128.
// - Full-scale calibration results land in the selected channel's full-scale register.
// - Choosing gain 1 or 128 loads the factory full-scale coefficient for that gain.
// - System offset calibration completes in two conversion cycles.
// - System full-scale needs host's full-scale input; device completes it in two cycles.
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`include "amcs_consts.vh"
module amcs_sequencer #(
  parameter [23:0] FS_TRIM_G1 = 24'h500000,
  parameter [23:0] FS_TRIM_G128 = 24'h4F0000
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address and data
  input wire awvalid,
  output wire awready,
  input wire [4:0] awaddr,
  input wire [2:0] awprot,
  input wire wvalid,
  output wire wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // AXI4-Lite write response
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  // AXI4-Lite read
  input wire arvalid,
  output wire arready,
  input wire [4:0] araddr,
  input wire [2:0] arprot,
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  // Modulator side
  input wire conv_clk,
  input wire [23:0] meas_data,
  // Analog control
  output wire ready_n,
  output wire filter_reset,
  output wire mod_reset,
  output wire mod_clk_en,
  output wire analog_power_on,
  output wire low_side_switch_on,
  output wire burnout_on,
  output wire input_short,
  output wire fs_ref_connect,
  // Interrupt
  output wire irq
);
  localparam [3:0] S_CONV = 4'h1;
  localparam [3:0] S_IDLE = 4'h2;
  localparam [3:0] S_PDOWN = 4'h4;
  localparam [3:0] S_CAL = 4'h8;

  reg [3:0] state;
  reg [2:0] mode;
  reg [2:0] cal_len;
  reg [2:0] cal_cnt;
  reg rdy_n;
  reg [2:0] chan;
  reg [2:0] gain;
  reg burnout_en;
  reg [2:0] irq_stat;
  reg [2:0] irq_mask;
  reg [23:0] off_coef [0:2];
  reg [23:0] fs_coef [0:2];
  reg cclk_s1;
  reg cclk_s2;
  reg cclk_s3;
  reg aw_held;
  reg w_held;
  reg [4:0] wr_addr;
  reg [31:0] wr_data;
  reg [3:0] wr_strb;
  reg [2:0] next_mode;
  reg [2:0] ev;
  reg [1:0] ci;
  integer i;

  wire tick = cclk_s2 & ~cclk_s3;
  wire wr_go = aw_held & w_held & ~bvalid;
  wire mode_wr = wr_go && wr_addr == `AMCS_OFS_MODE && wr_strb[0];
  wire cfg_wr = wr_go && wr_addr == `AMCS_OFS_CONFIG;
  wire ch_ok = chan < 3'h3;
  wire cal_last = tick && cal_cnt == cal_len - 3'h1;
  wire [4:0] rd_addr = {araddr[4:2], 2'b00};

  assign awready = ~aw_held & ~bvalid;
  assign wready = ~w_held & ~bvalid;
  assign arready = ~rvalid;
  assign irq = |(irq_stat & irq_mask);

  // Outputs follow the state flops
  assign ready_n = rdy_n;
  assign filter_reset = state != S_CONV && state != S_CAL;
  assign mod_reset = filter_reset;
  assign mod_clk_en = state != S_PDOWN;
  assign analog_power_on = state != S_PDOWN;
  assign low_side_switch_on = state != S_PDOWN;
  assign burnout_on = burnout_en && state != S_PDOWN;
  assign input_short = state == S_CAL && mode == `AMCS_MD_ZS_CAL;
  assign fs_ref_connect = state == S_CAL && mode == `AMCS_MD_FS_CAL;

  // Conversion-cycle edges come from the modulator domain, so two flops first
  always @(posedge aclk) begin
    if (!aresetn) begin
      cclk_s1 <= 1'b0;
      cclk_s2 <= 1'b0;
      cclk_s3 <= 1'b0;
    end else begin
      cclk_s1 <= conv_clk;
      cclk_s2 <= cclk_s1;
      cclk_s3 <= cclk_s2;
    end
  end

  // Write channel capture; address and data may arrive in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 5'h00;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `AMCS_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        wr_addr <= {awaddr[4:2], 2'b00};
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        if (wr_addr > `AMCS_OFS_FS_COEF)
          bresp <= `AMCS_RESP_SLVERR;
        else
          bresp <= `AMCS_RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `AMCS_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= `AMCS_RESP_OKAY;
      if (rd_addr == `AMCS_OFS_MODE) begin
        rdata <= {29'h0, mode};
      end else if (rd_addr == `AMCS_OFS_CONFIG) begin
        rdata <= {23'h0, burnout_en, 1'b0, gain, 1'b0, chan};
      end else if (rd_addr == `AMCS_OFS_STATUS) begin
        rdata <= {27'h0, state, rdy_n};
      end else if (rd_addr == `AMCS_OFS_IRQ_STAT) begin
        rdata <= {29'h0, irq_stat};
      end else if (rd_addr == `AMCS_OFS_IRQ_MASK) begin
        rdata <= {29'h0, irq_mask};
      end else if (rd_addr == `AMCS_OFS_OFF_COEF) begin
        rdata <= ch_ok ? {8'h00, off_coef[ci]} : 32'h00000000;
      end else if (rd_addr == `AMCS_OFS_FS_COEF) begin
        rdata <= ch_ok ? {8'h00, fs_coef[ci]} : 32'h00000000;
      end else begin
        rdata <= 32'h00000000;
        rresp <= `AMCS_RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  always @* begin
    ci = chan[1:0];
    next_mode = wr_data[2:0];
  end

  // Configuration, mask and sticky interrupt status
  always @(posedge aclk) begin
    if (!aresetn) begin
      chan <= 3'h0;
      gain <= `AMCS_RST_GAIN;
      burnout_en <= 1'b0;
      irq_mask <= 3'h0;
      irq_stat <= 3'h0;
    end else begin
      if (cfg_wr && wr_strb[0]) begin
        chan <= wr_data[`AMCS_CFG_CH_LSB +: 3];
        gain <= wr_data[`AMCS_CFG_GAIN_LSB +: 3];
      end
      if (cfg_wr && wr_strb[1])
        burnout_en <= wr_data[`AMCS_CFG_BO_BIT];
      if (wr_go && wr_addr == `AMCS_OFS_IRQ_MASK && wr_strb[0])
        irq_mask <= wr_data[2:0];
      // A new event wins over a clear in the same cycle
      if (wr_go && wr_addr == `AMCS_OFS_IRQ_STAT && wr_strb[0])
        irq_stat <= (irq_stat & ~wr_data[2:0]) | ev;
      else
        irq_stat <= irq_stat | ev;
    end
  end

  // Mode sequencer and coefficient storage
  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= S_CONV;
      mode <= `AMCS_MD_CONT;
      rdy_n <= 1'b1;
      cal_cnt <= 3'h0;
      cal_len <= `AMCS_CAL_CYC_SHORT;
      ev <= 3'h0;
      for (i = 0; i < 3; i = i + 1) begin
        off_coef[i] <= `AMCS_RST_OFF_COEF;
        fs_coef[i] <= `AMCS_RST_FS_COEF;
      end
    end else begin
      ev <= 3'h0;
      // Factory trim loads when gain 1 or 128 is chosen
      if (cfg_wr && wr_strb[0] && wr_data[2:0] < 3'h3) begin
        if (wr_data[`AMCS_CFG_GAIN_LSB +: 3] == `AMCS_GAIN_1)
          fs_coef[wr_data[1:0]] <= FS_TRIM_G1;
        else if (wr_data[`AMCS_CFG_GAIN_LSB +: 3] == `AMCS_GAIN_128)
          fs_coef[wr_data[1:0]] <= FS_TRIM_G128;
      end
      if (mode_wr) begin
        mode <= next_mode;
        cal_cnt <= 3'h0;
        case (next_mode)
          `AMCS_MD_CONT, `AMCS_MD_SINGLE: begin
            state <= S_CONV;
            rdy_n <= 1'b1;
          end
          `AMCS_MD_IDLE: begin
            state <= S_IDLE;
          end
          `AMCS_MD_PDOWN: begin
            state <= S_PDOWN;
          end
          default: begin
            // Gain 128 cannot run internal full-scale; refuse and park idle
            if (next_mode == `AMCS_MD_FS_CAL && gain == `AMCS_GAIN_128) begin
              state <= S_IDLE;
              mode <= `AMCS_MD_IDLE;
              ev[`AMCS_IRQ_REFUSE] <= 1'b1;
            end else begin
              state <= S_CAL;
              rdy_n <= 1'b1;
              if (next_mode == `AMCS_MD_FS_CAL && gain != `AMCS_GAIN_1)
                cal_len <= `AMCS_CAL_CYC_LONG;
              else
                cal_len <= `AMCS_CAL_CYC_SHORT;
            end
          end
        endcase
      end else begin
        case (state)
          S_CONV: begin
            if (tick) begin
              rdy_n <= 1'b0;
              ev[`AMCS_IRQ_CONV] <= 1'b1;
              // Single conversion powers down once its result is in
              if (mode == `AMCS_MD_SINGLE)
                state <= S_PDOWN;
            end
          end
          S_CAL: begin
            if (tick)
              cal_cnt <= cal_cnt + 3'h1;
            if (cal_last) begin
              rdy_n <= 1'b0;
              state <= S_IDLE;
              mode <= `AMCS_MD_IDLE;
              ev[`AMCS_IRQ_CAL] <= 1'b1;
              if (ch_ok) begin
                if (mode == `AMCS_MD_ZS_CAL || mode == `AMCS_MD_SYS_OFF)
                  off_coef[ci] <= meas_data;
                else
                  fs_coef[ci] <= meas_data;
              end
            end
          end
          S_IDLE: begin
            state <= S_IDLE;
          end
          S_PDOWN: begin
            state <= S_PDOWN;
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// ### sim/amcs_checker.sv
module amcs_checker (
  // Clock, reset and link
  input logic aclk,
  input logic aresetn,
  input logic conv_clk,
  // Control outputs
  input logic ready_n,
  input logic filter_reset,
  input logic mod_reset,
  input logic mod_clk_en,
  input logic analog_power_on,
  input logic low_side_switch_on,
  input logic burnout_on,
  input logic input_short,
  input logic fs_ref_connect
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic ck_q;
  logic [3:0] cnt;
  // Counts raw link rises while a calibration path is closed; the design sees each two cycles later
  always @(posedge aclk) begin
    ck_q <= conv_clk;
    if (!input_short && !fs_ref_connect) cnt <= 4'h0;
    else if (conv_clk && !ck_q) cnt <= cnt + 4'h1;
  end
  pdown_off_a: assert property (!mod_clk_en |-> !analog_power_on && !low_side_switch_on && !burnout_on)
    else $error("power-down left a circuit on");
  idle_rst_a: assert property (filter_reset == mod_reset)
    else $error("filter and modulator resets differ");
  cal_rdy_a: assert property (input_short || fs_ref_connect |-> ready_n)
    else $error("ready low during calibration");
  cal_excl_a: assert property (input_short |-> !fs_ref_connect && !filter_reset)
    else $error("short overlaps another path");
  zs_len_a: assert property ($fell(input_short) |-> cnt == 4'h2)
    else $error("zero-scale length wrong");
  fs_len_a: assert property ($fell(fs_ref_connect) |-> cnt == 4'h2 || cnt == 4'h4)
    else $error("full-scale length wrong");
  cal_idle_a: assert property ($fell(input_short) || $fell(fs_ref_connect) |-> filter_reset && !ready_n)
    else $error("no idle after calibration");
  rdy_fall_a: assert property ($fell(ready_n) |-> !input_short && !fs_ref_connect)
    else $error("ready fell inside calibration");
  zs_c: cover property ($fell(input_short));
  fs_c: cover property ($fell(fs_ref_connect));
  pd_c: cover property ($fell(mod_clk_en));
endmodule

bind amcs_sequencer amcs_checker u_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .conv_clk(conv_clk),
  .ready_n(ready_n),
  .filter_reset(filter_reset),
  .mod_reset(mod_reset),
  .mod_clk_en(mod_clk_en),
  .analog_power_on(analog_power_on),
  .low_side_switch_on(low_side_switch_on),
  .burnout_on(burnout_on),
  .input_short(input_short),
  .fs_ref_connect(fs_ref_connect)
);

// ### sim/amcs_mod_model.sv
module amcs_mod_model (
  // Frame control
  input logic run,
  input logic [23:0] coef,
  // Modulator outputs
  output logic conv_clk,
  output logic [23:0] meas_data
);
  timeunit 1ns;
  timeprecision 100ps;
  // Stands still between frames so no stray conversion cycle is counted
  always begin
    conv_clk = 1'h0;
    wait (run);
    #62.5 conv_clk = 1'h1;
    #62.5;
  end
  assign meas_data = run ? coef : ~coef;
endmodule

// ### sim/amcs_sequencer_tb_top.sv
module amcs_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // Bus master and link stimulus
  logic aclk = 1'h0, aresetn = 1'h0, run = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [31:0] wdata = 32'h0, d;
  logic [3:0] wstrb = 4'hF;
  logic [23:0] coef = 24'h0;
  logic [1:0] rs;
  // Design and modulator-model outputs
  wire awready, wready, bvalid, arready, rvalid, ready_n, filter_reset, mod_reset, mod_clk_en, irq;
  wire analog_power_on, low_side_switch_on, burnout_on, input_short, fs_ref_connect, conv_clk;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [23:0] meas_data;
  int err_count = 0, compares = 0, ticks = 0;
  always #2.5 aclk = ~aclk;
  always @(posedge conv_clk) ticks++;
  amcs_sequencer #(.FS_TRIM_G1(24'h3A5C11), .FS_TRIM_G128(24'h2B4D22)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .conv_clk(conv_clk), .meas_data(meas_data),
    .ready_n(ready_n), .filter_reset(filter_reset), .mod_reset(mod_reset), .mod_clk_en(mod_clk_en),
    .analog_power_on(analog_power_on), .low_side_switch_on(low_side_switch_on), .burnout_on(burnout_on),
    .input_short(input_short), .fs_ref_connect(fs_ref_connect),
    .irq(irq)
  );
  amcs_mod_model i_mod (.run(run), .coef(coef), .conv_clk(conv_clk), .meas_data(meas_data));

  task automatic close_out();
    if (err_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen === exp) return;
    err_count++;
    $display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
  endtask

  task automatic lim(input int n);
    if (n < 200) return;
    err_count++;
    close_out();
  endtask

  // One edge first, so back-to-back calls never drive a signal twice in one step
  task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    {awaddr, araddr, wdata} <= {a, a, v};
    {awvalid, wvalid, bready} <= {3{we}};
    {arvalid, rready} <= {2{!we}};
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (arready) arvalid <= 1'h0;
    end while (!(we ? bvalid : rvalid) && n < 200);
    {d, rs} = {rdata, we ? bresp : rresp};
    {bready, rready} <= 2'h0;
    lim(n);
  endtask

  task automatic go(input logic [2:0] m, input int n_exp, input logic [23:0] c, input logic [4:0] a);
    int n;
    coef <= c;
    bus(1'h1, 5'h00, {29'h0, m});
    chk(rs, 2'h0);
    chk({ready_n, input_short, fs_ref_connect}, {1'h1, m == 3'h4, m == 3'h5});
    ticks = 0;
    run <= 1'h1;
    for (n = 0; n < 200 && ready_n; n++)
      @(posedge aclk);
    run <= 1'h0;
    lim(n);
    chk(ticks, n_exp);
    if (!m[2]) return;
    bus(1'h0, 5'h08, 32'h0);
    chk(d[4:1], 4'h2);
    bus(1'h0, 5'h00, 32'h0);
    chk(d[2:0], 3'h2);
    bus(1'h0, a, 32'h0);
    chk(d[23:0], c);
  endtask

  // Continuous stays converting; single ends in power-down
  task automatic conv_scn();
    go(3'h0, 1, 24'h0, 5'h00);
    bus(1'h0, 5'h08, 32'h0);
    chk(d[4:0], 5'h02);
    go(3'h1, 1, 24'h0, 5'h00);
    bus(1'h0, 5'h08, 32'h0);
    chk(d[4:0], 5'h08);
  endtask

  // Channel 1 at a middle gain: the internal full-scale run takes the long count
  task automatic cal_scn();
    bus(1'h1, 5'h04, 32'h11);
    go(3'h4, 2, 24'h123456, 5'h14);
    go(3'h5, 4, 24'h234567, 5'h18);
    go(3'h6, 2, 24'h345678, 5'h14);
    go(3'h7, 2, 24'h456789, 5'h18);
  endtask

  task automatic trim_scn();
    bus(1'h1, 5'h04, 32'h01);
    bus(1'h0, 5'h18, 32'h0);
    chk(d[23:0], 24'h3A5C11);
    go(3'h5, 2, 24'h56789A, 5'h18);
    bus(1'h1, 5'h10, 32'h4);
    bus(1'h1, 5'h04, 32'h171);
    bus(1'h0, 5'h18, 32'h0);
    chk({irq, d[23:0]}, {1'h0, 24'h2B4D22});
  endtask

  // Refused request must leave ready low and raise only the unmasked bit
  task automatic refuse_scn();
    bus(1'h1, 5'h00, 32'h5);
    bus(1'h0, 5'h08, 32'h0);
    chk({irq, d[4:0]}, 6'h24);
    bus(1'h1, 5'h0C, 32'h4);
    chk(irq, 1'h0);
  endtask

  task automatic power_scn();
    bus(1'h1, 5'h00, 32'h2);
    chk({filter_reset, mod_reset, mod_clk_en, burnout_on}, 4'hF);
    bus(1'h1, 5'h00, 32'h3);
    chk({mod_clk_en, analog_power_on, low_side_switch_on, burnout_on, filter_reset}, 5'h01);
  endtask

  // Unmapped word answers with an error on both channels
  task automatic err_scn();
    bus(1'h1, 5'h1C, 32'h5);
    chk(rs, 2'h2);
    bus(1'h0, 5'h1C, 32'h0);
    chk(rs, 2'h2);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk({ready_n, filter_reset, mod_clk_en}, 3'h5);
    conv_scn();
    cal_scn();
    trim_scn();
    refuse_scn();
    power_scn();
    err_scn();
    close_out();
  end
endmodule
